/* File: hw/mphg_bus_state.v */
`timescale 1ns/1ps
`include "mphg_defines.vh"

// ============================================================
// Processor bus-state tracker: T1 from the latch strobe, then T2, T3,
// one wait state on reads, and the fourth state on reads only.
module mphg_bus_state (
  clk,
  rst,
  ce,
  ale,
  read_cycle,
  state_t1,
  state_t2,
  state_t3,
  state_tw,
  fourth_bus_state
);
  input wire clk;
  input wire rst;
  input wire ce;
  input wire ale;
  input wire read_cycle;
  output reg state_t1;
  output reg state_t2;
  output reg state_t3;
  output reg state_tw;
  output reg fourth_bus_state;

  // Shift chain; writes never reach the wait and fourth states.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_t1 <= 1'b0;
      state_t2 <= 1'b0;
      state_t3 <= 1'b0;
      state_tw <= 1'b0;
      fourth_bus_state <= 1'b0;
    end else if (ce) begin
      state_t1 <= ale;
      state_t2 <= state_t1;
      state_t3 <= state_t2;
      state_tw <= state_t3 & read_cycle;
      fourth_bus_state <= state_tw;
    end
  end
endmodule

/* File: hw/mphg_defines.vh */
`ifndef MPHG_DEFINES_VH
`define MPHG_DEFINES_VH

// ============================================================
// Controller count and plane layout.
`define MPHG_NUM_CTRL 4
`define MPHG_PLANES_PER_CTRL 4
`define MPHG_BCAST_LINE 4
`define MPHG_DATA_W 16
`define MPHG_ADDR_W 4

// ============================================================
// Register byte offsets of the host command port.
`define MPHG_OFS_CTRL 4'h0
`define MPHG_OFS_STATUS 4'h4
`define MPHG_OFS_ACT 4'h8
`define MPHG_OFS_EVENTS 4'hC

// ============================================================
// Control register fields and reset value.
`define MPHG_CTRL_EN_BIT 0
`define MPHG_CTRL_PRES_LO 4
`define MPHG_CTRL_PRES_HI 7
`define MPHG_CTRL_RESET 16'h00F1

// ============================================================
// Status register fields.
`define MPHG_ST_ISYNC_BIT 0
`define MPHG_ST_DSYNC_BIT 1
`define MPHG_ST_ONEACT_BIT 2
`define MPHG_ST_COLL_BIT 3
`define MPHG_ST_EDE_LO 4
`define MPHG_ST_EDE_HI 7
`define MPHG_ST_BST_LO 8
`define MPHG_ST_BST_HI 12

// ============================================================
// Activity shadow reset value and event counter width.
`define MPHG_ACT_RESET 16'hFFFF
`define MPHG_EVT_W 16

`endif

/* File: hw/mphg_sync_and.v */
`timescale 1ns/1ps
`include "mphg_defines.vh"

// ============================================================
// Registered wired-AND of the sync outputs of the present controllers.
module mphg_sync_and #(
  parameter N = 4
) (
  clk,
  rst,
  ce,
  present,
  sync_outs,
  composite
);
  input wire clk;
  input wire rst;
  input wire ce;
  input wire [N-1:0] present;
  input wire [N-1:0] sync_outs;
  output reg composite;

  wire composite_nxt;

  // Absent controllers read as ready, so they never hold the node low.
  assign composite_nxt = &(sync_outs | ~present);

  // The composite is registered so the fed-back input is glitch free.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      composite <= 1'b0;
    end else if (ce) begin
      composite <= composite_nxt;
    end
  end
endmodule

/* File: hw/mphg_top.v */
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "mphg_defines.vh"


// ============================================================
// Host glue between a 16-bit processor bus and four plane controllers.
module mphg_top (
  clk,
  rst,
  ce,
  ale,
  rd_n,
  bus_data_enable_n,
  cpu_addr,
  periph_select_line_n,
  ext_driver_enable_n,
  instr_sync_out,
  display_sync_out,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  ctrl_cs_n,
  reg_sel,
  instr_sync_in,
  display_sync_in,
  xcvr_oe_n,
  pix_xcvr_oe_n,
  xcvr_dir_read,
  fourth_bus_state
);
  input wire clk;
  input wire rst;
  input wire ce;
  input wire ale;
  input wire rd_n;
  input wire bus_data_enable_n;
  input wire [3:1] cpu_addr;
  input wire [4:0] periph_select_line_n;
  input wire [3:0] ext_driver_enable_n;
  input wire [3:0] instr_sync_out;
  input wire [3:0] display_sync_out;
  input wire [`MPHG_ADDR_W-1:0] reg_addr;
  input wire [`MPHG_DATA_W-1:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [`MPHG_DATA_W-1:0] reg_rdata;
  output reg [3:0] ctrl_cs_n;
  output reg [1:0] reg_sel;
  output wire instr_sync_in;
  output wire display_sync_in;
  output reg [3:0] xcvr_oe_n;
  output reg [1:0] pix_xcvr_oe_n;
  output reg xcvr_dir_read;
  output wire fourth_bus_state;

  // ============================================================
  // Access kind states, one-hot.
  localparam [2:0] ACC_IDLE = 3'h1;
  localparam [2:0] ACC_SINGLE = 3'h2;
  localparam [2:0] ACC_BCAST = 3'h4;

  // ============================================================
  // Host registers and internal state.
  reg [`MPHG_DATA_W-1:0] ctrl_r;
  reg [`MPHG_DATA_W-1:0] act_r;
  reg [`MPHG_EVT_W-1:0] evt_r;
  reg coll_r;
  reg [2:0] acc_r;
  reg [2:0] acc_nxt;
  reg [3:0] target_r;
  reg a3_r;
  reg read_cut_r;
  reg [3:0] cs_nxt;
  reg [3:0] oe_nxt;
  reg [1:0] pix_nxt;
  reg [`MPHG_DATA_W-1:0] rdata_nxt;

  wire glue_en;
  wire [3:0] present;
  wire read_cycle;
  wire den_act;
  wire [3:0] ede_act;
  wire [3:0] sel_lines;
  wire bcast_line;
  wire qualified;
  wire one_active;
  wire multi_ede;
  wire pixel_acc;
  wire st_t1;
  wire st_t2;
  wire st_t3;
  wire st_tw;
  wire wr_ctrl;
  wire wr_act;
  wire wr_events;
  wire [4:0] bus_state;
  wire [`MPHG_DATA_W-1:0] status_word;

  assign glue_en = ctrl_r[`MPHG_CTRL_EN_BIT];
  assign present = ctrl_r[`MPHG_CTRL_PRES_HI:`MPHG_CTRL_PRES_LO];
  assign read_cycle = ~rd_n;
  assign den_act = ~bus_data_enable_n;
  assign ede_act = ~ext_driver_enable_n;
  assign sel_lines = ~periph_select_line_n[3:0];
  assign bcast_line = ~periph_select_line_n[`MPHG_BCAST_LINE];
  assign pixel_acc = acc_r[2] & a3_r;
  assign bus_state = {fourth_bus_state, st_tw, st_t3, st_t2, st_t1};

  // Selects are valid only once the latch strobe has fallen.
  assign qualified = glue_en & ~ale;

  // Two or more driver enables during a by-plane read mean a bus collision.
  assign multi_ede = (ede_act & (ede_act - 4'h1)) != 4'h0;

  // Exactly one activity bit across all controllers for by-plane reads.
  assign one_active = (act_r != 16'h0000) &&
                      ((act_r & (act_r - 16'h0001)) == 16'h0000);

  // ============================================================
  // Sync composites, one registered AND per handshake.
  mphg_sync_and #(
    .N(`MPHG_NUM_CTRL)
  ) u_instr_and (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .present(present),
    .sync_outs(instr_sync_out),
    .composite(instr_sync_in)
  );

  mphg_sync_and #(
    .N(`MPHG_NUM_CTRL)
  ) u_display_and (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .present(present),
    .sync_outs(display_sync_out),
    .composite(display_sync_in)
  );

  // ============================================================
  // Bus-state tracker that marks the fourth state of reads.
  mphg_bus_state u_bus_state (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ale(ale),
    .read_cycle(read_cycle),
    .state_t1(st_t1),
    .state_t2(st_t2),
    .state_t3(st_t3),
    .state_tw(st_tw),
    .fourth_bus_state(fourth_bus_state)
  );

  // ============================================================
  // Address latch: register selects and A3 follow the strobe.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_sel <= 2'h0;
      a3_r <= 1'b0;
    end else if (ce && ale) begin
      reg_sel <= cpu_addr[2:1];
      a3_r <= cpu_addr[3];
    end
  end

  // ============================================================
  // Access decode: broadcast line beats individual lines.
  always @* begin
    acc_nxt = ACC_IDLE;
    if (!qualified) begin
      acc_nxt = ACC_IDLE;
    end else if (bcast_line) begin
      acc_nxt = ACC_BCAST;
    end else if (sel_lines != 4'h0) begin
      acc_nxt = ACC_SINGLE;
    end
  end

  // Chip selects, active low, one per controller.
  always @* begin
    cs_nxt = 4'hF;
    case (acc_nxt)
      ACC_BCAST: begin
        cs_nxt = ~present;
      end
      ACC_SINGLE: begin
        cs_nxt = ~(sel_lines & present);
      end
      default: begin
        cs_nxt = 4'hF;
      end
    endcase
  end

  // ============================================================
  // Read cut-off: held from the fourth state until the next strobe.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      read_cut_r <= 1'b0;
    end else if (ce) begin
      if (ale) begin
        read_cut_r <= 1'b0;
      end else if (fourth_bus_state) begin
        read_cut_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // Transceiver enables for regular and by-pixel paths.
  always @* begin
    oe_nxt = 4'hF;
    pix_nxt = 2'h3;
    if (!den_act || fourth_bus_state || read_cut_r) begin
      oe_nxt = 4'hF;
      pix_nxt = 2'h3;
    end else if (pixel_acc) begin
      // Both by-pixel parts assemble or split nibbles together.
      if (!read_cycle || (ede_act & present) != 4'h0) begin
        pix_nxt = 2'h0;
      end
    end else if (acc_r[2] || acc_r[1]) begin
      if (read_cycle) begin
        oe_nxt = ~(target_r & ede_act);
      end else begin
        oe_nxt = ~target_r;
      end
    end
  end

  // ============================================================
  // Output registers for selects, enables and direction.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= ACC_IDLE;
      target_r <= 4'h0;
      ctrl_cs_n <= 4'hF;
      xcvr_oe_n <= 4'hF;
      pix_xcvr_oe_n <= 2'h3;
      xcvr_dir_read <= 1'b0;
    end else if (ce) begin
      acc_r <= acc_nxt;
      target_r <= ~cs_nxt;
      ctrl_cs_n <= cs_nxt;
      xcvr_oe_n <= oe_nxt;
      pix_xcvr_oe_n <= pix_nxt;
      xcvr_dir_read <= read_cycle;
    end
  end

  // ============================================================
  // Collision monitor for by-plane block reads; set wins over clear.
  assign wr_events = reg_wr && (reg_addr == `MPHG_OFS_EVENTS);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coll_r <= 1'b0;
    end else if (ce) begin
      if (read_cycle && den_act && !pixel_acc && multi_ede) begin
        coll_r <= 1'b1;
      end else if (wr_events && reg_wdata[`MPHG_ST_COLL_BIT]) begin
        coll_r <= 1'b0;
      end
    end
  end

  // Counts completed controller reads that reached the fourth state.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_r <= {`MPHG_EVT_W{1'b0}};
    end else if (ce) begin
      if (wr_events && reg_wdata[`MPHG_ST_COLL_BIT]) begin
        evt_r <= {`MPHG_EVT_W{1'b0}};
      end else if (fourth_bus_state && acc_r != ACC_IDLE) begin
        evt_r <= evt_r + 16'h0001;
      end
    end
  end

  // ============================================================
  // Command port writes: control and activity shadow.
  assign wr_ctrl = reg_wr && (reg_addr == `MPHG_OFS_CTRL);
  assign wr_act = reg_wr && (reg_addr == `MPHG_OFS_ACT);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `MPHG_CTRL_RESET;
      act_r <= `MPHG_ACT_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata & 16'h00F1;
      end
      if (wr_act) begin
        // Mirrors the four activity bits loaded into each controller.
        act_r <= reg_wdata;
      end
    end
  end

  // ============================================================
  // Status word and read mux; unmapped offsets read zero.
  assign status_word = {3'h0, bus_state, ede_act, coll_r, one_active,
                        display_sync_in, instr_sync_in};

  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_addr == `MPHG_OFS_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (reg_addr == `MPHG_OFS_STATUS) begin
      rdata_nxt = status_word;
    end else if (reg_addr == `MPHG_OFS_ACT) begin
      rdata_nxt = act_r;
    end else if (reg_addr == `MPHG_OFS_EVENTS) begin
      rdata_nxt = evt_r;
    end
  end

  // Read data stands in the cycle after the strobe only.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end
endmodule

/* File: tb/mphg_ctrl_model.sv */
`timescale 1ns/1ps

// ============================================================
// Four plane controllers as seen from the glue's far side.
module mphg_ctrl_model (
  input wire clk,
  input wire rst,
  input wire [3:0] ctrl_cs_n,
  input wire [1:0] reg_sel,
  input wire [15:0] act_bits,
  input wire [3:0] isync_rdy,
  input wire [3:0] dsync_rdy,
  output logic [3:0] ext_driver_enable_n,
  output wire [3:0] instr_sync_out,
  output wire [3:0] display_sync_out
);
  // Each controller reports readiness; only the glue joins them.
  assign instr_sync_out = isync_rdy;
  assign display_sync_out = dsync_rdy;

  // Driver enable lags chip select by a clock, FIFO port only, and needs
  // one active plane, so planeless controllers stay off the bus.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_driver_enable_n <= 4'hF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ext_driver_enable_n[i] <= !(!ctrl_cs_n[i] && reg_sel == 2'h3 &&
          act_bits[4*i +: 4] != 4'h0);
      end
    end
  end
endmodule

/* File: tb/mphg_top_monitor.sv */
`timescale 1ns/1ps

// ============================================================
// Port checker for the host glue.
module mphg_top_monitor (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire ale,
  input wire bus_data_enable_n,
  input wire [3:1] cpu_addr,
  input wire [4:0] periph_select_line_n,
  input wire [3:0] ext_driver_enable_n,
  input wire [3:0] instr_sync_out,
  input wire [3:0] display_sync_out,
  input wire [3:0] ctrl_cs_n,
  input wire [1:0] reg_sel,
  input wire instr_sync_in,
  input wire display_sync_in,
  input wire [3:0] xcvr_oe_n,
  input wire [1:0] pix_xcvr_oe_n,
  input wire xcvr_dir_read,
  input wire fourth_bus_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Composites, selects and transceiver gating.
  chk_sync_instr: assert property (ce |=> instr_sync_in ==
    &$past(instr_sync_out)) else $error("bad instr composite");
  chk_sync_disp: assert property (ce |=> display_sync_in ==
    &$past(display_sync_out)) else $error("bad display composite");
  chk_reg_select: assert property (ce && ale |=>
    reg_sel == $past(cpu_addr[2:1])) else $error("bad reg select");
  chk_ale_qual: assert property (ce && ale |=>
    ctrl_cs_n == 4'hF) else $error("select during latch strobe");
  chk_bcast_all: assert property (ce && !ale &&
    !periph_select_line_n[4] |=> ctrl_cs_n == 4'h0)
    else $error("broadcast missed a controller");
  chk_single_cs: assert property (ce && !ale &&
    periph_select_line_n[4] |=> ctrl_cs_n == $past(periph_select_line_n[3:0]))
    else $error("wrong single select");
  chk_read_gate: assert property (xcvr_dir_read &&
    xcvr_oe_n != 4'hF |-> !$past(bus_data_enable_n) &&
    ((~xcvr_oe_n & $past(ext_driver_enable_n)) == 4'h0))
    else $error("read enable without gating");
  chk_t4_cutoff: assert property (fourth_bus_state |->
    $past(ale, 5) ##1 (xcvr_oe_n == 4'hF && pix_xcvr_oe_n == 2'h3))
    else $error("transceivers on after fourth state");
  chk_pix_pair: assert property (pix_xcvr_oe_n[0] ==
    pix_xcvr_oe_n[1]) else $error("pixel pair split");
  chk_regular_cs: assert property ((~xcvr_oe_n &
    ctrl_cs_n) == 4'h0) else $error("unselected transceiver on");
endmodule

bind mphg_top mphg_top_monitor mphg_top_monitor_inst (.clk(clk), .rst(rst),
  .ce(ce), .ale(ale), .bus_data_enable_n(bus_data_enable_n),
  .cpu_addr(cpu_addr), .periph_select_line_n(periph_select_line_n),
  .ext_driver_enable_n(ext_driver_enable_n),
  .instr_sync_out(instr_sync_out), .display_sync_out(display_sync_out),
  .ctrl_cs_n(ctrl_cs_n), .reg_sel(reg_sel), .instr_sync_in(instr_sync_in),
  .display_sync_in(display_sync_in), .xcvr_oe_n(xcvr_oe_n),
  .pix_xcvr_oe_n(pix_xcvr_oe_n), .xcvr_dir_read(xcvr_dir_read),
  .fourth_bus_state(fourth_bus_state));

/* File: tb/mphg_top_tb.sv */
`timescale 1ns/1ps

// ============================================================
// Self-checking bench: glue plus four modelled controllers.
module mphg_top_tb;
  typedef struct packed {
    logic [4:0] psl;
    logic [2:0] adr;
    logic rd;
    logic [15:0] act;
    logic [3:0] cs;
    logic [3:0] oe;
    logic [1:0] pix;
  } mphg_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ale = 1'h0;
  logic rd_n = 1'h1;
  logic den_n = 1'h1;
  logic [3:1] cpu_addr = 3'h0;
  logic [4:0] psl_n = 5'h1F;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] act = 16'hFFFF;
  logic [3:0] irdy = 4'hF;
  logic [3:0] drdy = 4'hF;
  logic [3:0] ede_n, iso, dso, cs_n, oe_n;
  logic [15:0] rdata, v;
  logic [1:0] rsel, pix_n;
  logic isi, dsi, dir, t4;
  int fail_count = 0;
  int checks_done = 0;
  mphg_row_t rows [9];

  mphg_top mphg_top_inst (.clk(clk), .rst(rst), .ce(1'h1), .ale(ale),
    .rd_n(rd_n), .bus_data_enable_n(den_n), .cpu_addr(cpu_addr),
    .periph_select_line_n(psl_n), .ext_driver_enable_n(ede_n),
    .instr_sync_out(iso), .display_sync_out(dso), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .ctrl_cs_n(cs_n), .reg_sel(rsel),
    .instr_sync_in(isi), .display_sync_in(dsi), .xcvr_oe_n(oe_n),
    .pix_xcvr_oe_n(pix_n), .xcvr_dir_read(dir), .fourth_bus_state(t4));
  mphg_ctrl_model mphg_ctrl_model_inst (.clk(clk), .rst(rst),
    .ctrl_cs_n(cs_n), .reg_sel(rsel), .act_bits(act), .isync_rdy(irdy),
    .dsync_rdy(drdy), .ext_driver_enable_n(ede_n), .instr_sync_out(iso),
    .display_sync_out(dso));

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  // Compares and counts, reporting a mismatch at once.
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Register port: one-cycle strobes, read data the cycle after.
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask

  // One processor bus cycle: latch strobe, select, data enable, release.
  task automatic run(input mphg_row_t r);
    @(posedge clk);
    ale <= 1'h1;
    cpu_addr <= r.adr;
    rd_n <= !r.rd;
    act <= r.act;
    @(posedge clk);
    ale <= 1'h0;
    psl_n <= r.psl;
    repeat (2) @(posedge clk);
    den_n <= 1'h0;
    @(posedge clk);
    @(negedge clk);
    chk("enables", {cs_n, oe_n, pix_n, 5'h00, dir},
      {r.cs, r.oe, r.pix, 5'h00, r.rd});
    @(negedge clk);
    chk("fourth state", {15'h0, t4}, {15'h0, r.rd});
    repeat (2) @(posedge clk);
    den_n <= 1'h1;
    @(posedge clk);
    psl_n <= 5'h1F;
    rd_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask

  // Limit on the whole run.
  initial begin
    #2500000;
    fail_count++;
    stop_test();
  end

  // Main sequence: reset, registers, bus cycles, syncs, mid-run reset.
  initial begin
    rows = '{
      {5'h1D, 3'h3, 1'h1, 16'h00F0, 4'hD, 4'hD, 2'h3},
      {5'h1B, 3'h0, 1'h1, 16'hFFFF, 4'hB, 4'hF, 2'h3},
      {5'h17, 3'h0, 1'h0, 16'h0000, 4'h7, 4'h7, 2'h3},
      {5'h0F, 3'h1, 1'h0, 16'hFFFF, 4'h0, 4'h0, 2'h3},
      {5'h0F, 3'h4, 1'h0, 16'hFFFF, 4'h0, 4'hF, 2'h0},
      {5'h0F, 3'h7, 1'h1, 16'hFFFF, 4'h0, 4'hF, 2'h0},
      {5'h0F, 3'h3, 1'h1, 16'h0100, 4'h0, 4'hB, 2'h3},
      {5'h0E, 3'h0, 1'h0, 16'h0000, 4'h0, 4'h0, 2'h3},
      {5'h0F, 3'h3, 1'h1, 16'h0110, 4'h0, 4'h9, 2'h3}};
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("reset outputs", {cs_n, oe_n, pix_n, rsel, isi, dsi, dir, t4},
      16'hFFC0);
    reg_read(4'h0, v);
    chk("control", v, 16'h00F1);
    reg_read(4'h8, v);
    chk("activity", v, 16'hFFFF);
    reg_write(4'h2, 16'hFFFF);
    reg_read(4'h2, v);
    chk("unmapped", v, 16'h0000);
    $display("reset and register test done");
    foreach (rows[k]) run(rows[k]);
    reg_read(4'h4, v);
    chk("collision", {15'h0, v[3]}, 16'h0001);
    reg_read(4'hC, v);
    chk("fourth count", v, 16'h0005);
    reg_write(4'hC, 16'h0008);
    reg_read(4'hC, v);
    chk("count clear", v, 16'h0000);
    reg_write(4'h8, 16'h0010);
    reg_read(4'h4, v);
    chk("one active", {14'h0, v[3:2]}, 16'h0001);
    reg_write(4'h8, 16'h0011);
    reg_read(4'h4, v);
    chk("two active", {15'h0, v[2]}, 16'h0000);
    $display("bus cycle test done");
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      irdy <= 4'hF ^ (4'h1 << k);
      drdy <= 4'hF ^ (4'h8 >> k);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("sync", {14'h0, isi, dsi}, {14'h0, &irdy, &drdy});
    end
    reg_write(4'h0, 16'h0011);
    reg_read(4'h0, v);
    chk("lone control", v, 16'h0011);
    @(negedge clk);
    chk("read data drop", rdata, 16'h0000);
    @(posedge clk);
    irdy <= 4'hE;
    drdy <= 4'hE;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("lone sync low", {14'h0, isi, dsi}, 16'h0000);
    @(posedge clk);
    irdy <= 4'hF;
    drdy <= 4'hF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("lone sync high", {14'h0, isi, dsi}, 16'h0003);
    reg_write(4'h0, 16'h00F1);
    $display("sync test done");
    @(posedge clk);
    psl_n <= 5'h0F;
    repeat (2) @(posedge clk);
    rst <= 1'h1;
    @(negedge clk);
    chk("select in reset", {12'h0, cs_n}, 16'h000F);
    @(posedge clk);
    rst <= 1'h0;
    psl_n <= 5'h1F;
    reg_read(4'h8, v);
    chk("activity after reset", v, 16'hFFFF);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
